// *** bmc_params.svh ***
`ifndef BMC_PARAMS_SVH
`define BMC_PARAMS_SVH

// register byte addresses in the memory space
`define BMC_OFS_SHARED_BG      32'h0040_0004
`define BMC_OFS_SHARED_FG      32'h0040_0008
`define BMC_OFS_MONO_CTL       32'h0040_000C
`define BMC_OFS_ENGINE_CTL     32'h0040_0010
`define BMC_OFS_SRC_BG         32'h0040_0024
`define BMC_OFS_SRC_FG         32'h0040_0028

// writable bits of each register; everything else is reserved and reads zero, except control bit 31 which reads busy
`define BMC_COLOR_RW_MASK      32'h00FF_FFFF
`define BMC_MONO_RW_MASK       32'h0F3F_3F3F
`define BMC_CTL_RW_MASK        32'h03FF_FFFF

// reset values
`define BMC_COLOR_RST          32'h0000_0000
`define BMC_MONO_RST           32'h0000_0000
`define BMC_CTL_RST            32'h0000_0000

// mono source control fields
`define BMC_MONO_EXPSEL_BIT    27
`define BMC_MONO_ALIGN_HI      26
`define BMC_MONO_ALIGN_LO      24
`define BMC_MONO_DISC_HI       21
`define BMC_MONO_DISC_LO       16
`define BMC_MONO_RCLIP_HI      13
`define BMC_MONO_RCLIP_LO      8
`define BMC_MONO_LCLIP_HI      5
`define BMC_MONO_LCLIP_LO      0

// engine control fields
`define BMC_CTL_BUSY_BIT       31
`define BMC_CTL_DEPTH_HI       25
`define BMC_CTL_DEPTH_LO       24
`define BMC_CTL_DEPSEL_BIT     23
`define BMC_CTL_SRCMONO_BIT    12
`define BMC_CTL_LOW_HI         22

// colour byte masks per depth
`define BMC_CMASK_8            24'h00_00FF
`define BMC_CMASK_16           24'h00_FFFF
`define BMC_CMASK_24           24'hFF_FFFF

`endif

// *** bmc_pkg.sv ***
package bmc_pkg;

    // engine colour depth codes
    typedef enum logic [1:0] {
        BMC_DEPTH_8   = 2'h0,
        BMC_DEPTH_16  = 2'h1,
        BMC_DEPTH_24  = 2'h2,
        BMC_DEPTH_RSV = 2'h3
    } bmc_depth_t;

    // mono source scan line alignment codes
    typedef enum logic [2:0] {
        BMC_ALN_RSV0  = 3'h0,
        BMC_ALN_BIT   = 3'h1,
        BMC_ALN_BYTE  = 3'h2,
        BMC_ALN_WORD  = 3'h3,
        BMC_ALN_DWORD = 3'h4,
        BMC_ALN_QWORD = 3'h5,
        BMC_ALN_RSV6  = 3'h6,
        BMC_ALN_RSV7  = 3'h7
    } bmc_align_t;

endpackage

// *** bmc_regs.sv ***
// Notes on behaviour
// - foreground uses byte 0 at 8bpp, bytes 0-1 at 16bpp, bytes 0-2 at 24bpp.
// - select bit 0 expands mono source with shared colours, 1 with source-only ones.
// - shared foreground always drives pattern; source-only foreground serves source when selected.
// - alignment codes 1..5 are bit, byte, word, dword, qword; others reserved.
// - alignment, discard and clipping apply only to monochrome source.
// - initial discard drops up to 63 bits from the first source quadword.
// - right clipping drops up to 63 bits at each scan line end.
// - left clipping drops up to 63 bits at each scan line start.
// - reserved bits of mono control and engine control read as zero.
// - control bit 31 shows busy, is read-only, writes ignored.
// - depth field 00 8bpp (reset), 01 16bpp, 10 24bpp, 11 reserved.
// - depth select 0 takes depth from configuration bits 5:4, 1 from control.
// - selected depth sets bytes per pixel and mono expansion depth.
// - control bit 12 marks source as colour at 0, monochrome at 1.
// - shared background follows the same pattern/source use as foreground.
`timescale 1ns/1ps
`include "bmc_params.svh"

module bmc_regs (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_sys_rst,
    // host memory access
    input  wire logic [31:0]          i_mem_addr,
    input  wire logic                 i_mem_wr,
    input  wire logic                 i_mem_rd,
    input  wire logic [3:0]           i_mem_be,
    input  wire logic [31:0]          i_mem_wdata,
    output logic      [31:0]          o_mem_rdata,
    output logic                      o_mem_rvalid,
    // engine status and configuration
    input  wire logic [1:0]           i_cfg_depth,
    input  wire logic                 i_op_launch,
    input  wire logic                 i_last_dest_write_done,
    // decoded settings for the engine datapath
    output bmc_pkg::bmc_depth_t       o_depth,
    output logic      [1:0]           o_bytes_per_pixel,
    output logic      [23:0]          o_pat_fg,
    output logic      [23:0]          o_pat_bg,
    output logic      [23:0]          o_src_fg,
    output logic      [23:0]          o_src_bg,
    output logic                      o_src_mono,
    output bmc_pkg::bmc_align_t       o_src_align,
    output logic                      o_src_align_rsv,
    output logic      [5:0]           o_init_discard,
    output logic      [5:0]           o_left_clip,
    output logic      [5:0]           o_right_clip,
    output logic      [22:0]          o_ctl_low,
    output logic                      o_engine_busy
);
    import bmc_pkg::*;

    logic [31:0] lane_mask;
    logic        hit_sbg, hit_sfg, hit_mono, hit_ctl, hit_obg, hit_ofg;
    logic [31:0] shared_bg_ff, shared_fg_ff, mono_ctl_ff, ctl_ff, src_bg_ff, src_fg_ff;
    logic [31:0] nxt_shared_bg, nxt_shared_fg, nxt_mono_ctl, nxt_ctl, nxt_src_bg;
    logic [31:0] nxt_src_fg;
    logic        busy_ff, nxt_busy;
    logic [31:0] rd_mux;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rd_addr_ff, nxt_rd_addr;

    // byte lane enables widened to a bit mask; half-word writes touch two lanes only
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign lane_mask[8*g +: 8] = {8{i_mem_be[g]}};
        end
    endgenerate

    // address decode of the six registers
    assign hit_sbg  = (i_mem_addr == `BMC_OFS_SHARED_BG);
    assign hit_sfg  = (i_mem_addr == `BMC_OFS_SHARED_FG);
    assign hit_mono = (i_mem_addr == `BMC_OFS_MONO_CTL);
    assign hit_ctl  = (i_mem_addr == `BMC_OFS_ENGINE_CTL);
    assign hit_obg  = (i_mem_addr == `BMC_OFS_SRC_BG);
    assign hit_ofg  = (i_mem_addr == `BMC_OFS_SRC_FG);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] lm, input logic [31:0] rw);
        merge = (old & ~(lm & rw)) | (wd & lm & rw); // reserved bits never stored
    endfunction

    // register file next values
    always_comb
    begin
        nxt_shared_bg = shared_bg_ff;
        nxt_shared_fg = shared_fg_ff;
        nxt_mono_ctl  = mono_ctl_ff;
        nxt_ctl       = ctl_ff;
        nxt_src_bg    = src_bg_ff;
        nxt_src_fg    = src_fg_ff;
        if (i_mem_wr)
        begin
            if (hit_sbg)
                nxt_shared_bg = merge(shared_bg_ff, i_mem_wdata, lane_mask,
                                      `BMC_COLOR_RW_MASK);
            if (hit_sfg)
                nxt_shared_fg = merge(shared_fg_ff, i_mem_wdata, lane_mask,
                                      `BMC_COLOR_RW_MASK);
            if (hit_mono)
                nxt_mono_ctl = merge(mono_ctl_ff, i_mem_wdata, lane_mask,
                                     `BMC_MONO_RW_MASK);
            if (hit_ctl)
                nxt_ctl = merge(ctl_ff, i_mem_wdata, lane_mask,
                                `BMC_CTL_RW_MASK);
            if (hit_obg)
                nxt_src_bg = merge(src_bg_ff, i_mem_wdata, lane_mask, `BMC_COLOR_RW_MASK);
            if (hit_ofg)
                nxt_src_fg = merge(src_fg_ff, i_mem_wdata, lane_mask, `BMC_COLOR_RW_MASK);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            shared_bg_ff <= `BMC_COLOR_RST;
            shared_fg_ff <= `BMC_COLOR_RST;
            mono_ctl_ff  <= `BMC_MONO_RST;
            ctl_ff       <= `BMC_CTL_RST;
            src_bg_ff    <= `BMC_COLOR_RST;
            src_fg_ff    <= `BMC_COLOR_RST;
        end
        else
        begin
            shared_bg_ff <= nxt_shared_bg;
            shared_fg_ff <= nxt_shared_fg;
            mono_ctl_ff  <= nxt_mono_ctl;
            ctl_ff       <= nxt_ctl;
            src_bg_ff    <= nxt_src_bg;
            src_fg_ff    <= nxt_src_fg;
        end
    end

    // busy: a launch in the same cycle as the final write keeps it set
    always_comb
    begin
        nxt_busy = busy_ff;
        if (i_last_dest_write_done)
            nxt_busy = 1'b0;
        if (i_op_launch)
            nxt_busy = 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            busy_ff <= 1'b0;
        else
            busy_ff <= nxt_busy;
    end

    assign o_engine_busy = busy_ff;

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_sbg)
            rd_mux = shared_bg_ff;
        if (hit_sfg)
            rd_mux = shared_fg_ff;
        if (hit_mono)
            rd_mux = mono_ctl_ff;
        if (hit_ctl)
        begin
            rd_mux = ctl_ff;
            rd_mux[`BMC_CTL_BUSY_BIT] = busy_ff;
        end
        if (hit_obg)
            rd_mux = src_bg_ff;
        if (hit_ofg)
            rd_mux = src_fg_ff;
        nxt_rdata   = i_mem_rd ? rd_mux : rdata_ff;
        nxt_rvalid  = i_mem_rd;
        nxt_rd_addr = i_mem_rd ? i_mem_addr : rd_addr_ff;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            rdata_ff   <= 32'h0000_0000;
            rvalid_ff  <= 1'b0;
            rd_addr_ff <= 32'h0000_0000;
        end
        else
        begin
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
            rd_addr_ff <= nxt_rd_addr;
        end
    end

    assign o_mem_rdata  = rdata_ff;
    assign o_mem_rvalid = rvalid_ff;

    // decoded engine settings, registered so the datapath sees stable values
    bmc_depth_t  depth_sel, depth_ff;
    logic [23:0] cmask;
    logic [1:0]  bpp, bpp_ff;
    logic        mono_src, mono_src_ff, exp_sel;
    logic [23:0] pat_fg_ff, pat_bg_ff, sfg_ff, sbg_ff;
    logic [23:0] nxt_pat_fg, nxt_pat_bg, nxt_sfg, nxt_sbg;
    logic [2:0]  align_raw;
    bmc_align_t  align_ff, nxt_align;
    logic        align_rsv_ff, nxt_align_rsv;
    logic [5:0]  disc_ff, lclip_ff, rclip_ff, nxt_disc, nxt_lclip, nxt_rclip;
    logic [22:0] ctl_low_ff;

    always_comb
    begin
        // depth source select; reserved code 11 falls back to one byte per pixel
        if (ctl_ff[`BMC_CTL_DEPSEL_BIT])
            depth_sel = bmc_depth_t'(ctl_ff[`BMC_CTL_DEPTH_HI:`BMC_CTL_DEPTH_LO]);
        else
            depth_sel = bmc_depth_t'(i_cfg_depth);
        case (depth_sel)
            BMC_DEPTH_16:
            begin
                cmask = `BMC_CMASK_16;
                bpp   = 2'h2;
            end
            BMC_DEPTH_24:
            begin
                cmask = `BMC_CMASK_24;
                bpp   = 2'h3;
            end
            default:
            begin
                cmask = `BMC_CMASK_8;
                bpp   = 2'h1;
            end
        endcase
        mono_src = ctl_ff[`BMC_CTL_SRCMONO_BIT];
        exp_sel  = mono_ctl_ff[`BMC_MONO_EXPSEL_BIT];
        nxt_pat_fg = shared_fg_ff[23:0] & cmask;
        nxt_pat_bg = shared_bg_ff[23:0] & cmask;
        nxt_sfg = (exp_sel ? src_fg_ff[23:0] : shared_fg_ff[23:0]) & cmask;
        nxt_sbg = (exp_sel ? src_bg_ff[23:0] : shared_bg_ff[23:0]) & cmask;
        align_raw = mono_ctl_ff[`BMC_MONO_ALIGN_HI:`BMC_MONO_ALIGN_LO];
        // colour source zeroes the mono-only fields so the datapath cannot misuse them
        nxt_align     = mono_src ? bmc_align_t'(align_raw) : BMC_ALN_RSV0;
        nxt_align_rsv = mono_src && (align_raw == 3'h0 || align_raw > 3'h5);
        nxt_disc  = mono_src ? mono_ctl_ff[`BMC_MONO_DISC_HI:`BMC_MONO_DISC_LO]
                             : 6'h00;
        nxt_rclip = mono_src ? mono_ctl_ff[`BMC_MONO_RCLIP_HI:`BMC_MONO_RCLIP_LO]
                             : 6'h00;
        nxt_lclip = mono_src ? mono_ctl_ff[`BMC_MONO_LCLIP_HI:`BMC_MONO_LCLIP_LO]
                             : 6'h00;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            depth_ff     <= BMC_DEPTH_8;
            bpp_ff       <= 2'h1;
            pat_fg_ff    <= 24'h00_0000;
            pat_bg_ff    <= 24'h00_0000;
            sfg_ff       <= 24'h00_0000;
            sbg_ff       <= 24'h00_0000;
            mono_src_ff  <= 1'b0;
            align_ff     <= BMC_ALN_RSV0;
            align_rsv_ff <= 1'b0;
            disc_ff      <= 6'h00;
            lclip_ff     <= 6'h00;
            rclip_ff     <= 6'h00;
            ctl_low_ff   <= 23'h00_0000;
        end
        else
        begin
            depth_ff     <= depth_sel;
            bpp_ff       <= bpp;
            pat_fg_ff    <= nxt_pat_fg;
            pat_bg_ff    <= nxt_pat_bg;
            sfg_ff       <= nxt_sfg;
            sbg_ff       <= nxt_sbg;
            mono_src_ff  <= mono_src;
            align_ff     <= nxt_align;
            align_rsv_ff <= nxt_align_rsv;
            disc_ff      <= nxt_disc;
            lclip_ff     <= nxt_lclip;
            rclip_ff     <= nxt_rclip;
            ctl_low_ff   <= ctl_ff[`BMC_CTL_LOW_HI:0];
        end
    end

    assign o_depth           = depth_ff;
    assign o_bytes_per_pixel = bpp_ff;
    assign o_pat_fg          = pat_fg_ff;
    assign o_pat_bg          = pat_bg_ff;
    assign o_src_fg          = sfg_ff;
    assign o_src_bg          = sbg_ff;
    assign o_src_mono        = mono_src_ff;
    assign o_src_align       = align_ff;
    assign o_src_align_rsv   = align_rsv_ff;
    assign o_init_discard    = disc_ff;
    assign o_left_clip       = lclip_ff;
    assign o_right_clip      = rclip_ff;
    assign o_ctl_low         = ctl_low_ff;

    // checks
    busy_launch_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_op_launch |=> o_engine_busy)
        else $error("busy not set after launch");
    busy_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_engine_busy && !i_last_dest_write_done |=> o_engine_busy)
        else $error("busy dropped before last write");
    busy_end_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_last_dest_write_done && !i_op_launch |=> !o_engine_busy)
        else $error("busy stuck after last write");
    busy_wr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_mem_wr && hit_ctl && !o_engine_busy && !i_op_launch |=> !o_engine_busy)
        else $error("control write changed busy");
    rsvd_read_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_mem_rvalid && rd_addr_ff == `BMC_OFS_MONO_CTL |->
        (o_mem_rdata & ~`BMC_MONO_RW_MASK) == 32'h0000_0000)
        else $error("mono control reserved bits not zero");
    depth_mask_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_bytes_per_pixel == 2'h1 |-> o_pat_fg[23:8] == 16'h0000 && o_src_fg[23:8] == 16'h0000)
        else $error("colour bytes leak at 8bpp");
    depth_src_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !ctl_ff[`BMC_CTL_DEPSEL_BIT] && $stable(ctl_ff) |=> o_depth == $past(i_cfg_depth))
        else $error("depth not taken from configuration");
    exp_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !exp_sel ##1 $stable(exp_sel) |-> o_src_fg == o_pat_fg && o_src_bg == o_pat_bg)
        else $error("source colours not shared");
    colour_src_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !o_src_mono |-> o_left_clip == 6'h00 && o_right_clip == 6'h00 && o_init_discard == 6'h00)
        else $error("clip fields applied to colour source");
    lane_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        i_mem_wr && hit_mono && !i_mem_be[0] |=> $stable(mono_ctl_ff[7:0]))
        else $error("uncovered byte lane modified");

endmodule

// *** bmc_host_model.sv ***
`timescale 1ns/1ps

module bmc_host_model (
    // clock
    input  wire logic        i_sys_clk,
    // memory bus towards the register bank
    output logic      [31:0] o_mem_addr,
    output logic             o_mem_wr,
    output logic             o_mem_rd,
    output logic      [3:0]  o_mem_be,
    output logic      [31:0] o_mem_wdata,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic        i_mem_rvalid
);
    // idle bus at time zero
    initial
    begin
        o_mem_addr  = 32'h0000_0000;
        o_mem_wr    = 1'b0;
        o_mem_rd    = 1'b0;
        o_mem_be    = 4'h0;
        o_mem_wdata = 32'h0000_0000;
    end

    // one write, held across exactly one sampling edge
    task automatic wr(input logic [31:0] addr, input logic [3:0] be, input logic [31:0] data);
        @(posedge i_sys_clk);
        #1;
        o_mem_addr  = addr;
        o_mem_be    = be;
        o_mem_wdata = data;
        o_mem_wr    = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_mem_wr    = 1'b0;
        // stale data would hide a lane that is stored late
        o_mem_wdata = ~data;
    endtask

    // one read; data and valid are taken while the answer stands
    task automatic rd(input logic [31:0] addr, output logic [31:0] data, output logic valid);
        @(posedge i_sys_clk);
        #1;
        o_mem_addr = addr;
        o_mem_rd   = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_mem_rd = 1'b0;
        valid    = i_mem_rvalid;
        data     = i_mem_rdata;
    endtask
endmodule

// *** blit_mono_source_and_depth_control_test.sv ***
`timescale 1ns/1ps
`include "bmc_params.svh"

module blit_mono_source_and_depth_control_test;
    import bmc_pkg::*;

    logic        sys_clk;
    logic        sys_rst;
    logic [31:0] mem_addr;
    logic        mem_wr;
    logic        mem_rd;
    logic [3:0]  mem_be;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic        mem_rvalid;
    logic [1:0]  cfg_depth;
    logic        op_launch;
    logic        dest_done;
    bmc_depth_t  depth;
    bmc_align_t  src_align;
    logic [1:0]  bpp;
    logic [23:0] pat_fg;
    logic [23:0] pat_bg;
    logic [23:0] src_fg;
    logic [23:0] src_bg;
    logic        src_mono;
    logic        align_rsv;
    logic [5:0]  discard;
    logic [5:0]  lclip;
    logic [5:0]  rclip;
    logic [22:0] ctl_low;
    logic        busy;
    int          fail_count;
    int          compares;

    bmc_host_model host (
        .i_sys_clk(sys_clk), .o_mem_addr(mem_addr), .o_mem_wr(mem_wr), .o_mem_rd(mem_rd),
        .o_mem_be(mem_be), .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata),
        .i_mem_rvalid(mem_rvalid)
    );

    bmc_regs dut (
        .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_mem_addr(mem_addr), .i_mem_wr(mem_wr),
        .i_mem_rd(mem_rd), .i_mem_be(mem_be), .i_mem_wdata(mem_wdata),
        .o_mem_rdata(mem_rdata), .o_mem_rvalid(mem_rvalid), .i_cfg_depth(cfg_depth),
        .i_op_launch(op_launch), .i_last_dest_write_done(dest_done), .o_depth(depth),
        .o_bytes_per_pixel(bpp), .o_pat_fg(pat_fg), .o_pat_bg(pat_bg), .o_src_fg(src_fg),
        .o_src_bg(src_bg), .o_src_mono(src_mono), .o_src_align(src_align),
        .o_src_align_rsv(align_rsv), .o_init_discard(discard), .o_left_clip(lclip),
        .o_right_clip(rclip), .o_ctl_low(ctl_low), .o_engine_busy(busy)
    );

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // read through the host and judge valid and data together
    task automatic rchk(input string name, input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        host.rd(addr, d, v);
        chk("rvalid", {31'h0, v}, 32'h0000_0001);
        chk(name, d, exp);
    endtask

    // decoded outputs trail the register by one more edge
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse(input logic launch, input logic done);
        @(posedge sys_clk);
        #1;
        op_launch = launch;
        dest_done = done;
        @(posedge sys_clk);
        #1;
        op_launch = 1'b0;
        dest_done = 1'b0;
    endtask

    task automatic test_reset();
        rchk("mono", `BMC_OFS_MONO_CTL, 32'h0000_0000);
        rchk("ctl", `BMC_OFS_ENGINE_CTL, 32'h0000_0000);
        chk("depth", {30'h0, depth}, 32'h0000_0000);
        chk("bpp", {30'h0, bpp}, 32'h0000_0001);
        chk("busy", {31'h0, busy}, 32'h0000_0000);
    endtask

    task automatic test_reserved();
        host.wr(`BMC_OFS_MONO_CTL, 4'hF, 32'hFFFF_FFFF);
        rchk("mono", `BMC_OFS_MONO_CTL, 32'h0F3F_3F3F);
        host.wr(`BMC_OFS_ENGINE_CTL, 4'hF, 32'hFFFF_FFFF);
        rchk("ctl", `BMC_OFS_ENGINE_CTL, 32'h03FF_FFFF);
        settle();
        chk("ctl_low", {9'h0, ctl_low}, 32'h007F_FFFF);
        host.wr(32'h0040_0030, 4'hF, 32'h1234_5678);
        rchk("unmapped", 32'h0040_0030, 32'h0000_0000);
        // half-word writes leave the other lanes alone
        host.wr(`BMC_OFS_ENGINE_CTL, 4'h3, 32'h0000_0000);
        rchk("ctl_lo", `BMC_OFS_ENGINE_CTL, 32'h03FF_0000);
        host.wr(`BMC_OFS_ENGINE_CTL, 4'hC, 32'h0000_0000);
        rchk("ctl_hi", `BMC_OFS_ENGINE_CTL, 32'h0000_0000);
    endtask

    task automatic test_depth();
        logic [23:0] m;
        host.wr(`BMC_OFS_SHARED_FG, 4'hF, 32'h00AB_CDEF);
        host.wr(`BMC_OFS_SHARED_BG, 4'hF, 32'h0012_3456);
        for (int d = 0; d < 4; d++)
        begin
            host.wr(`BMC_OFS_ENGINE_CTL, 4'hF, 32'h0080_0000 | (d << 24));
            settle();
            m = (d == 1) ? 24'h00_FFFF : (d == 2) ? 24'hFF_FFFF : 24'h00_00FF;
            chk("depth", {30'h0, depth}, d);
            chk("bpp", {30'h0, bpp}, (d == 1) ? 2 : (d == 2) ? 3 : 1);
            chk("pat_fg", {8'h0, pat_fg}, {8'h0, 24'hAB_CDEF & m});
            chk("pat_bg", {8'h0, pat_bg}, {8'h0, 24'h12_3456 & m});
        end
        for (int d = 0; d < 3; d++)
        begin
            // depth select 0 takes the configuration depth even with the control depth field at 11
            cfg_depth = d[1:0];
            host.wr(`BMC_OFS_ENGINE_CTL, 4'hF, 32'h0300_0000);
            settle();
            chk("cfg_depth", {30'h0, depth}, d);
        end
        cfg_depth = 2'h0;
    endtask

    task automatic test_expand();
        host.wr(`BMC_OFS_SRC_FG, 4'hF, 32'h0077_8899);
        host.wr(`BMC_OFS_SRC_BG, 4'hF, 32'h00AA_BBCC);
        host.wr(`BMC_OFS_ENGINE_CTL, 4'hF, 32'h0280_1000);
        host.wr(`BMC_OFS_MONO_CTL, 4'hF, 32'h0000_0000);
        settle();
        chk("src_fg", {8'h0, src_fg}, 32'h00AB_CDEF);
        chk("src_bg", {8'h0, src_bg}, 32'h0012_3456);
        host.wr(`BMC_OFS_MONO_CTL, 4'hF, 32'h0800_0000);
        settle();
        chk("src_fg", {8'h0, src_fg}, 32'h0077_8899);
        chk("src_bg", {8'h0, src_bg}, 32'h00AA_BBCC);
        chk("pat_fg", {8'h0, pat_fg}, 32'h00AB_CDEF);
        chk("pat_bg", {8'h0, pat_bg}, 32'h0012_3456);
    endtask

    task automatic test_mono();
        for (int a = 0; a < 8; a++)
        begin
            host.wr(`BMC_OFS_MONO_CTL, 4'hF, 32'h003F_2A15 | (a << 24));
            settle();
            chk("src_mono", {31'h0, src_mono}, 32'h0000_0001);
            chk("align", {29'h0, src_align}, a);
            chk("align_rsv", {31'h0, align_rsv}, (a == 0 || a > 5));
            chk("discard", {26'h0, discard}, 32'h0000_003F);
            chk("rclip", {26'h0, rclip}, 32'h0000_002A);
            chk("lclip", {26'h0, lclip}, 32'h0000_0015);
        end
        // upper half-word write must leave the clipping lanes alone
        host.wr(`BMC_OFS_MONO_CTL, 4'hC, 32'h0000_0000);
        rchk("mono_lo", `BMC_OFS_MONO_CTL, 32'h0000_2A15);
        // colour source hides alignment, discard and both clipping fields
        host.wr(`BMC_OFS_ENGINE_CTL, 4'hF, 32'h0280_0000);
        settle();
        chk("src_mono", {31'h0, src_mono}, 32'h0000_0000);
        chk("mono_off", {src_align, discard, rclip, lclip}, 32'h0000_0000);
    endtask

    task automatic test_busy();
        pulse(1'b1, 1'b0);
        chk("busy", {31'h0, busy}, 32'h0000_0001);
        host.wr(`BMC_OFS_ENGINE_CTL, 4'hF, 32'h0280_0000);
        rchk("ctl_busy", `BMC_OFS_ENGINE_CTL, 32'h8280_0000);
        pulse(1'b1, 1'b1);
        chk("busy_both", {31'h0, busy}, 32'h0000_0001);
        pulse(1'b0, 1'b1);
        chk("busy_done", {31'h0, busy}, 32'h0000_0000);
        rchk("ctl_idle", `BMC_OFS_ENGINE_CTL, 32'h0280_0000);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // the whole run needs a few hundred cycles at most
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end

    initial
    begin
        sys_clk    = 1'b0;
        sys_rst    = 1'b1;
        cfg_depth  = 2'h0;
        op_launch  = 1'b0;
        dest_done  = 1'b0;
        fail_count = 0;
        compares   = 0;
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        test_reset();
        test_reserved();
        test_depth();
        test_expand();
        test_mono();
        test_busy();
        summarize();
    end
endmodule
